// *** core/pin_sync.sv ***
// two flip-flop synchroniser for the memory's data-out pin
// assumes the pin is asynchronous to mclk; first stage feeds only the second
`timescale 1ns/1ps

module pin_sync
    import sram_host_pkg::*;
(
    // clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // pin in, settled level out
    input  wire logic pinIn,
    output logic      levelOut
);

    // ****************************************************************
    // state
    // ****************************************************************
    sync_t s;       // registered stages
    sync_t next_s;  // next stages

    // shift the pin through two stages
    always_comb
    begin
        next_s.first  = pinIn;
        next_s.second = s.first;
    end

    // register; reset to the pulled-high idle level of the pin
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            s <= '{first: 1'b1, second: 1'b1};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign levelOut = s.second;

endmodule

// *** core/sram_host.sv ***
// host controller that drives a 1024 x 1 asynchronous static memory
// assumes the memory sits on the pins below with no clock of its own,
// and that the user side is on mclk (125 MHz) with synchronous reset
`timescale 1ns/1ps
`include "sram_host_defs.svh"

module sram_host
    import sram_host_pkg::*;
(
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    resetn,
    // user request
    input  wire logic                    reqValid,
    output logic                         reqReady,
    input  wire logic                    reqWrite,
    input  wire logic [`SRAM_ADDR_W-1:0] reqAddr,
    input  wire logic                    reqData,
    // user answer
    output logic                         rspValid,
    output logic                         rspData,
    // memory pins
    output logic [`SRAM_ADDR_W-1:0]      sramAddr,
    output logic                         sramSelectN,
    output logic                         sramWriteN,
    output logic                         sramDataIn,
    input  wire logic                    sramDataOut
);

    // ****************************************************************
    // derived counts, sized to the counter
    // ****************************************************************
    localparam logic [`CNT_W-1:0] READ_CYC  = `CNT_W'(`CYC_READ);        // wait for read data
    localparam logic [`CNT_W-1:0] SETUP_CYC = `CNT_W'(`CYC_SETUP);       // before strobe falls
    localparam logic [`CNT_W-1:0] PULSE_CYC = `CNT_W'(`CYC_PULSE);       // strobe low width
    localparam logic [`CNT_W-1:0] HOLD_CYC  = `CNT_W'(`CYC_HOLD);        // after strobe rises
    localparam logic [`CNT_W-1:0] DSET_CYC  = `CNT_W'(`CYC_DATA_SETUP);  // data before strobe end
    localparam logic [`CNT_W-1:0] WCYC_CYC  = `CNT_W'(`CYC_WRITE_CYCLE); // whole write cycle
    localparam logic [`CNT_W-1:0] TURN_CYC  = `CNT_W'(`CYC_TURN);        // output switch-off gap
    localparam logic [`CNT_W-1:0] ONE       = `CNT_W'(1);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // larger of two counts; the strobe must satisfy both its own width
    // and the data setup, since data is presented no earlier than setup
    function automatic logic [`CNT_W-1:0] maxCnt(input logic [`CNT_W-1:0] a,
                                                 input logic [`CNT_W-1:0] b);
        maxCnt = (a > b) ? a : b;
    endfunction

    // strobe width: data goes valid with the address, SETUP_CYC before
    // the strobe, so the pulse only has to cover the remainder of its setup
    localparam logic [`CNT_W-1:0] STROBE_CYC =
        maxCnt(PULSE_CYC, (DSET_CYC > SETUP_CYC) ? DSET_CYC - SETUP_CYC : ONE);

    // ****************************************************************
    // synchronised data-out pin
    // ****************************************************************
    logic dataOutSync;  // settled level of the memory output

    // the output is open collector or three-state; both idle high here,
    // and the bit is only sampled after the access time has run out
    pin_sync u_dout_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .pinIn    (sramDataOut),
        .levelOut (dataOutSync)
    );

    // ****************************************************************
    // state
    // ****************************************************************
    ctrl_t s;       // registered state
    ctrl_t next_s;  // next state

    // idle value: deselected, strobe high, no answer
    localparam ctrl_t IDLE_STATE = '{
        phase:    PH_IDLE,
        count:    '0,
        span:     '0,
        addr:     '0,
        selectN:  1'b1,
        writeN:   1'b1,
        dataIn:   1'b0,
        rspValid: 1'b0,
        rspData:  1'b0
    };

    // a request is taken only when idle; handshake is combinational
    assign reqReady = (s.phase == PH_IDLE);

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb
    begin
        next_s          = s;
        // answer is a one-cycle pulse
        next_s.rspValid = 1'b0;
        // count down the current phase
        if (s.count != '0)
        begin
            next_s.count = s.count - ONE;
        end
        // span counter from strobe fall to deselect, for the write cycle time
        if (s.span != '0 && s.span != '1)
        begin
            next_s.span = s.span + ONE;
        end

        unique case (s.phase)
            PH_IDLE:
            begin
                // select and address go out together; the memory decodes
                if (reqValid)
                begin
                    next_s.addr    = reqAddr;
                    next_s.selectN = 1'b0;
                    next_s.dataIn  = reqData;
                    next_s.span    = '0;
                    if (reqWrite)
                    begin
                        // address, select and data lead the strobe
                        next_s.phase = PH_SETUP;
                        next_s.count = SETUP_CYC - ONE;
                    end
                    else
                    begin
                        // strobe stays high: read
                        next_s.writeN = 1'b1;
                        next_s.phase  = PH_READ;
                        next_s.count  = READ_CYC - ONE;
                    end
                end
            end

            PH_READ:
            begin
                // wait covers address access and select access, both
                // counted from the same edge, plus the synchroniser
                if (s.count == '0)
                begin
                    next_s.rspData  = dataOutSync;
                    next_s.rspValid = 1'b1;
                    next_s.selectN  = 1'b1;
                    next_s.phase    = PH_TURN;
                    next_s.count    = TURN_CYC - ONE;
                end
            end

            PH_SETUP:
            begin
                // address and select have been stable for the setup time
                if (s.count == '0)
                begin
                    next_s.writeN = 1'b0;
                    next_s.phase  = PH_STROBE;
                    next_s.count  = STROBE_CYC - ONE;
                    next_s.span   = ONE;
                end
            end

            PH_STROBE:
            begin
                // the memory blanks its output meanwhile; nothing is sampled
                if (s.count == '0)
                begin
                    // bit is latched by the memory on this rising edge
                    next_s.writeN = 1'b1;
                    next_s.phase  = PH_HOLD;
                    next_s.count  = HOLD_CYC - ONE;
                end
            end

            PH_HOLD:
            begin
                // address, select and data held past the strobe's end;
                // also waits out the write cycle time from strobe fall
                if (s.count == '0 && s.span >= WCYC_CYC)
                begin
                    next_s.selectN  = 1'b1;
                    next_s.rspValid = 1'b1;
                    next_s.span     = '0;
                    next_s.phase    = PH_TURN;
                    next_s.count    = TURN_CYC - ONE;
                end
            end

            PH_TURN:
            begin
                // gap lets the output switch off before another device or
                // access is started; costs a few cycles per access
                if (s.count == '0)
                begin
                    next_s.phase = PH_IDLE;
                end
            end
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // synchronous reset to the idle, deselected state
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            s <= IDLE_STATE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ****************************************************************
    // outputs, all straight from the state register
    // ****************************************************************
    // the strobe is never low while select is high, so a deselected
    // memory always sees a plain idle bus
    assign sramAddr    = s.addr;
    assign sramSelectN = s.selectN;
    assign sramWriteN  = s.writeN;
    assign sramDataIn  = s.dataIn;
    assign rspValid    = s.rspValid;
    assign rspData     = s.rspData;

endmodule

// *** core/sram_host_defs.svh ***
// constants for the host controller of a 1024 x 1 asynchronous static memory
// assumes a single 125 MHz clock; every count is derived from a printed time in ns
// Operation
// - strobe held low at least 35 ns
// - address 5 ns before strobe, 5 after
// - data-in 40 ns before strobe end, 5 after
// - select 5 ns before strobe, 5 after
`ifndef SRAM_HOST_DEFS_SVH
`define SRAM_HOST_DEFS_SVH

// ****************************************************************
// clock and rounding
// ****************************************************************
`define CLK_PERIOD_NS       8
// least times round up to whole cycles, never below one
`define CYC_CEIL(ns)        ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                             (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

// ****************************************************************
// organisation
// ****************************************************************
`define SRAM_ADDR_W         10
`define SRAM_WORDS          1024
`define CNT_W               4

// ****************************************************************
// printed times, ns
// ****************************************************************
`define T_ADDR_ACCESS_NS    45
`define T_SEL_ACCESS_NS     30
`define T_SEL_OFF_NS        30
`define T_WE_OFF_NS         30
`define T_WE_RECOVER_NS     30
`define T_WE_PULSE_NS       35
`define T_ADDR_SETUP_NS     5
`define T_ADDR_HOLD_NS      5
`define T_DATA_SETUP_NS     40
`define T_DATA_HOLD_NS      5
`define T_SEL_SETUP_NS      5
`define T_SEL_HOLD_NS       5
`define T_WRITE_CYCLE_NS    45

// ****************************************************************
// derived cycle counts
// ****************************************************************
`define SYNC_STAGES         2
// read waits for the slower of address and select access, plus the synchroniser
`define CYC_READ            (`CYC_CEIL(`T_ADDR_ACCESS_NS) + `SYNC_STAGES)
`define CYC_SETUP           `CYC_CEIL(`T_ADDR_SETUP_NS)
`define CYC_PULSE           `CYC_CEIL(`T_WE_PULSE_NS)
`define CYC_HOLD            `CYC_CEIL(`T_ADDR_HOLD_NS)
`define CYC_DATA_SETUP      `CYC_CEIL(`T_DATA_SETUP_NS)
`define CYC_WRITE_CYCLE     `CYC_CEIL(`T_WRITE_CYCLE_NS)
// idle gap after deselect so a previous output has switched off
`define CYC_TURN            `CYC_CEIL(`T_SEL_OFF_NS)

`endif

// *** core/sram_host_pkg.sv ***
// types shared by the memory host controller and its pin synchroniser
// assumes the constants header sits beside it on the include path
`include "sram_host_defs.svh"

package sram_host_pkg;

    // ****************************************************************
    // controller phases
    // ****************************************************************
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_READ,
        PH_SETUP,
        PH_STROBE,
        PH_HOLD,
        PH_TURN
    } phase_t;

    // ****************************************************************
    // whole controller state
    // ****************************************************************
    typedef struct packed {
        phase_t                   phase;      // current phase
        logic [`CNT_W-1:0]        count;      // cycles left in phase
        logic [`CNT_W-1:0]        span;       // cycles since strobe fell
        logic [`SRAM_ADDR_W-1:0]  addr;       // address pins
        logic                     selectN;    // chip select pin
        logic                     writeN;     // write strobe pin
        logic                     dataIn;     // data-in pin
        logic                     rspValid;   // answer pulse
        logic                     rspData;    // read bit
    } ctrl_t;

    // two-stage synchroniser state
    typedef struct packed {
        logic first;                          // metastable stage
        logic second;                         // settled stage
    } sync_t;

endpackage

// *** test/async_sram_1k_by_1_tb_top.sv ***
// self-checking bench: controller plus behavioural memory, bench cell model
// assumes inputs change 1 ns after the rising edge of mclk
`timescale 1ns/1ps
`include "sram_host_defs.svh"

module async_sram_1k_by_1_tb_top;
    logic                    mclk;              // 125 MHz clock
    logic                    resetn;            // synchronous reset
    logic                    reqValid;          // user request
    logic                    reqWrite;          // write when high
    logic                    reqData;           // bit to write
    logic [`SRAM_ADDR_W-1:0] reqAddr;           // cell address
    logic                    reqReady;          // controller idle
    logic                    rspValid;          // answer pulse
    logic                    rspData;           // read bit
    logic [`SRAM_ADDR_W-1:0] sramAddr;          // address pins
    logic                    sramSelectN;       // select pin
    logic                    sramWriteN;        // strobe pin
    logic                    sramDataIn;        // data-in pin
    logic                    sramDataOut;       // memory output
    int                      mismatches;        // failed compares
    int                      checksDone;        // all compares
    bit                      refMem [int];      // bench copy of written cells

    // edges from the take edge to the edge where the answer is sampled high:
    // read waits out address access plus the synchroniser; write is setup,
    // strobe width and hold, which together also cover the write cycle time
    localparam int READ_ANS  = `CYC_READ + 1;
    localparam int WRITE_ANS = `CYC_SETUP + `CYC_PULSE + `CYC_HOLD + 1;

    sram_host u_dut (.mclk(mclk), .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
        .sramAddr(sramAddr), .sramSelectN(sramSelectN), .sramWriteN(sramWriteN), .sramDataIn(sramDataIn),
        .sramDataOut(sramDataOut));
    sram_cell_model #(.DLY(28)) u_mem (.addr(sramAddr), .selectN(sramSelectN), .writeN(sramWriteN),
        .dataIn(sramDataIn), .dataOut(sramDataOut));

    // one compare, counted
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("compares %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one request held until taken, then wait for its answer
    task automatic access(input logic wr, input logic [`SRAM_ADDR_W-1:0] a, input logic d);
        int n;
        n = 0;
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = a;
        reqData = d;
        // a busy controller must leave the request waiting, not lose it
        while (!reqReady && n < 50)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        // a controller that never comes back to idle counts as a mismatch
        check(reqReady, 1'b1);
        @(posedge mclk);
        #1;
        reqValid = 1'b0;
        n = 0;
        while (!rspValid && n < 50)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        // n counts edges after the take; the answer is sampled high one edge later
        if (!wr)
        begin
            check(n + 1, READ_ANS);
            check(rspData, refMem[a]);
        end
        else
        begin
            check(n + 1, WRITE_ANS);
            refMem[a] = d;
        end
    endtask

    // free-running clock
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // hang guard, far beyond the expected run of at most 1630 cycles
    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        summarize();
    end

    // main sequence
    initial
    begin
        int unsigned r;
        r = $urandom(42345);
        resetn = 1'b0;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqData = 1'b0;
        reqAddr = '0;
        repeat (8) @(posedge mclk);
        #1;
        resetn = 1'b1;
        // end cells, both bit values, write then read back to back
        for (int k = 0; k < 4; k++)
        begin
            access(1'b1, k[0] ? 10'h3FF : 10'h000, k[1]);
            access(1'b0, k[0] ? 10'h3FF : 10'h000, 1'b0);
        end
        // random writes, overwrites included, then read every written cell back
        for (int k = 0; k < 60; k++)
            access(1'b1, 10'($urandom), 1'($urandom));
        foreach (refMem[a])
            access(1'b0, 10'(a), 1'($urandom));
        summarize();
    end
endmodule

// *** test/sram_cell_model.sv ***
// behavioural 1024 x 1 asynchronous memory on the controller's pins
// assumes open-collector output: off state is pulled high
`timescale 1ns/1ps
`include "sram_host_defs.svh"

module sram_cell_model
#(
    parameter int DLY = 28                       // output settle time, ns; 30 at most
)
(
    // pins driven by the controller
    input  wire logic [`SRAM_ADDR_W-1:0] addr,
    input  wire logic                    selectN,
    input  wire logic                    writeN,
    input  wire logic                    dataIn,
    // memory output pin
    output logic                         dataOut
);
    logic cells [`SRAM_WORDS];
    logic raw;                                   // level the cell array presents
    initial dataOut = 1'b1;
    // bit is stored at the strobe's end, only while selected
    always @(posedge writeN)
        if (!selectN)
            cells[addr] = dataIn;
    // decode: deselected or writing releases the output to the pull-up
    always @*
        raw = (selectN || !writeN) ? 1'b1 : cells[addr];
    // wrong level while settling, so an early sample cannot pass by luck
    always @(raw)
    begin
        dataOut <= #1 ~raw;
        dataOut <= #(DLY) raw;
    end
endmodule

// *** test/sram_host_chk.sv ***
// pin and handshake checks for the memory host controller
// assumes it is bound to sram_host and sees only its ports
`timescale 1ns/1ps
`include "sram_host_defs.svh"

module sram_host_chk
(
    // clock and reset
    input wire logic                    mclk,
    input wire logic                    resetn,
    // user side
    input wire logic                    reqValid,
    input wire logic                    reqReady,
    input wire logic                    reqWrite,
    input wire logic [`SRAM_ADDR_W-1:0] reqAddr,
    input wire logic                    reqData,
    input wire logic                    rspValid,
    input wire logic                    rspData,
    // memory pins
    input wire logic [`SRAM_ADDR_W-1:0] sramAddr,
    input wire logic                    sramSelectN,
    input wire logic                    sramWriteN,
    input wire logic                    sramDataIn,
    input wire logic                    sramDataOut
);
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    strobe_width_a: assert property (
        $fell(sramWriteN) |-> !sramWriteN[*5]) else $error("strobe shorter than 35 ns");
    strobe_setup_a: assert property (
        $fell(sramWriteN) |-> $past(!sramSelectN) && $stable(sramAddr)) else $error("no setup before strobe");
    strobe_steady_a: assert property (
        !sramWriteN |-> !sramSelectN && $stable(sramAddr) && $stable(sramDataIn)) else $error("pins moved in strobe");
    // one 8 ns cycle of hold covers the 5 ns; select may rise one edge after the strobe,
    // but address and data-in must not move at that edge either
    write_hold_a: assert property (
        $rose(sramWriteN) |-> (!sramSelectN && $stable(sramAddr) && $stable(sramDataIn))
        ##1 ($stable(sramAddr) && $stable(sramDataIn)))
        else $error("hold after strobe broken");
    take_address_a: assert property (
        reqValid && reqReady |=> !sramSelectN && sramAddr == $past(reqAddr)) else $error("address not driven");
    write_data_a: assert property (
        reqValid && reqReady && reqWrite |=> sramDataIn == $past(reqData)) else $error("data-in wrong");
    read_no_strobe_a: assert property (
        reqValid && reqReady && !reqWrite |=> sramWriteN[*8]) else $error("strobe during read");
    answer_time_a: assert property (
        reqValid && reqReady && !reqWrite |=> !rspValid[*8] ##1 rspValid) else $error("read answer not at 9 cycles");
    write_answer_a: assert property (
        reqValid && reqReady && reqWrite |=> !rspValid[*7] ##1 rspValid) else $error("write answer not at 8 cycles");
    busy_refuse_a: assert property (
        reqValid && reqReady |=> !reqReady[*8]) else $error("ready during access");
    turn_gap_a: assert property (
        $rose(sramSelectN) |-> sramSelectN[*4]) else $error("select back too soon");
    answer_pulse_a: assert property (
        rspValid |=> !rspValid) else $error("answer longer than one cycle");
endmodule

bind sram_host sram_host_chk u_chk (.mclk(mclk), .resetn(resetn), .reqValid(reqValid), .reqReady(reqReady),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid), .rspData(rspData),
    .sramAddr(sramAddr), .sramSelectN(sramSelectN), .sramWriteN(sramWriteN), .sramDataIn(sramDataIn),
    .sramDataOut(sramDataOut));
